// ### core/fan_pwm_pkg.sv
// Package with constants and carrier types of the fan PWM controller
package fan_pwm_pkg;

    // Control levels arrive as 8-bit codes: code 0 = 0% point, code 255 = 100% point
    localparam int LEVEL_W = 8;
    localparam logic [7:0] LEVEL_FULL = 8'hFF;
    localparam logic [7:0] LEVEL_ZERO = 8'h00;

    // PWM period: one step per enable pulse, 255 steps per period
    localparam int PWM_FREQ_HZ = 30;
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int STEP_DIV_DEF = CLK_FREQ_HZ / (PWM_FREQ_HZ * 255);
    localparam int STEP_DIV_W = 16;
    localparam logic [7:0] STEP_LAST = 8'hFE;

    // Cycle counts in PWM periods
    localparam logic [5:0] MISS_WINDOW_CYC = 6'h20;
    localparam logic [5:0] DIAG_CYC = 6'h03;
    localparam logic [5:0] STARTUP_CYC = 6'h20;
    localparam logic [5:0] CYC_ONE = 6'h01;
    localparam logic [5:0] CYC_ZERO = 6'h00;

    typedef enum logic [2:0] {
        ST_STARTUP,
        ST_STARTUP_RETRY,
        ST_RUN,
        ST_DIAG,
        ST_DIAG_RETRY,
        ST_FAULT
    } fan_state_t;

    typedef struct packed {
        logic [LEVEL_W-1:0] temp_control_level;
        logic [LEVEL_W-1:0] min_speed_level;
    } level_pair_t;

    typedef struct packed {
        fan_state_t state;
        logic [STEP_DIV_W-1:0] div_cnt;
        logic step_en;
        logic [7:0] phase;
        logic [7:0] duty;
        logic [5:0] cyc_cnt;
        logic pulse_seen;
        logic [2:0] pulse_sync;
        logic pulse_lvl;
        logic fan_drive_output;
        logic fault_n;
    } fan_regs_t;

endpackage

// ### core/fan_pwm_missing_pulse_ctrl.sv
// Temperature-proportional PWM fan drive with missing commutation pulse supervision

// Functional notes
// R1 - The control level maps linearly onto duty, lowest code 0% on-time and highest 100%.
// R2 - The minimum-speed level bounds the duty from below through the same mapping.
// R3 - The outside sensor network must span the full code range over the regulated range.
// R4 - A 32 PWM cycle window without a commutation pulse starts the diagnostic timer.
// R5 - The diagnostic timer holds the drive on for three PWM cycles while watching for pulses.
// R6 - A pulse during the diagnostic burst returns to proportional PWM with a fresh window.
// R7 - The outside circuit should keep the minimum-speed level high enough to avoid bursts.
// R8 - Each PWM cycle uses the greater of temperature and minimum-speed levels as duty.
// R9 - After reset the drive is held on for a 32 PWM cycle start-up period watching pulses.
// R10 - A pulseless burst is followed by one 32 cycle start-up, then normal run or fault.
// R11 - The fault state latches the low fault output and disables the drive until reset.
// R12 - Levels are sampled once per period and the duty applies from the next period start.
module fan_pwm_missing_pulse_ctrl #(
    parameter int STEP_DIV = fan_pwm_pkg::STEP_DIV_DEF
) (
    input wire logic ref_clk_i, // 200 MHz clock
    input wire logic sys_rst_i, // Synchronous reset, shutdown
    input wire fan_pwm_pkg::level_pair_t levels_i, // Temperature and min-speed codes
    input wire logic commutation_pulse_i, // Conditioned shunt pulse, async
    output logic fan_drive_output_o, // Low-side switch drive, high = on
    output logic fan_fault_n_o // Fault, active low, latched
);

    fan_pwm_pkg::fan_regs_t r_ff;
    fan_pwm_pkg::fan_regs_t nxt_r;
    logic [7:0] req_duty;
    logic period_end;
    logic pulse_evt;

    localparam logic [15:0] DIV_LAST = 16'(STEP_DIV - 1);

    // ******************************
    // Next-state logic
    // ******************************
    always_comb begin
        nxt_r = r_ff;
        // Greater of the two levels, both on the same scale
        if (levels_i.temp_control_level > levels_i.min_speed_level) begin // [R8] [R2]
            req_duty = levels_i.temp_control_level;
        end else begin
            req_duty = levels_i.min_speed_level;
        end
        // Step divider
        nxt_r.step_en = 1'b0;
        if (r_ff.div_cnt == DIV_LAST) begin
            nxt_r.div_cnt = '0;
            nxt_r.step_en = 1'b1;
        end else begin
            nxt_r.div_cnt = r_ff.div_cnt + 16'h0001;
        end
        period_end = r_ff.step_en && (r_ff.phase == fan_pwm_pkg::STEP_LAST);
        // Pulse synchroniser: stage 0 is read only by stage 1
        nxt_r.pulse_sync = {r_ff.pulse_sync[1:0], commutation_pulse_i};
        if (r_ff.pulse_sync[2] == r_ff.pulse_sync[1]) begin
            nxt_r.pulse_lvl = r_ff.pulse_sync[1];
        end
        pulse_evt = nxt_r.pulse_lvl && !r_ff.pulse_lvl;
        if (r_ff.step_en) begin
            nxt_r.phase = period_end ? 8'h00 : r_ff.phase + 8'h01;
        end
        if (period_end) begin
            nxt_r.duty = req_duty; // [R12]
        end
        // Pulse flag: a new pulse wins over the clear at period end
        if (period_end) begin
            nxt_r.pulse_seen = pulse_evt;
        end else if (pulse_evt) begin
            nxt_r.pulse_seen = 1'b1;
        end
        if (period_end) begin
            nxt_r.cyc_cnt = r_ff.cyc_cnt + fan_pwm_pkg::CYC_ONE;
        end
        unique case (r_ff.state)
            fan_pwm_pkg::ST_STARTUP, fan_pwm_pkg::ST_STARTUP_RETRY: begin
                if (r_ff.pulse_seen || pulse_evt) begin
                    nxt_r.state = fan_pwm_pkg::ST_RUN;
                    nxt_r.cyc_cnt = fan_pwm_pkg::CYC_ZERO;
                end else if (period_end && nxt_r.cyc_cnt == fan_pwm_pkg::STARTUP_CYC) begin // [R9]
                    nxt_r.cyc_cnt = fan_pwm_pkg::CYC_ZERO;
                    nxt_r.state = (r_ff.state == fan_pwm_pkg::ST_STARTUP) ?
                        fan_pwm_pkg::ST_STARTUP_RETRY : fan_pwm_pkg::ST_FAULT; // [R10]
                end
            end
            fan_pwm_pkg::ST_RUN: begin
                if (pulse_evt) begin
                    nxt_r.cyc_cnt = fan_pwm_pkg::CYC_ZERO;
                end else if (period_end && nxt_r.cyc_cnt == fan_pwm_pkg::MISS_WINDOW_CYC) begin
                    nxt_r.state = fan_pwm_pkg::ST_DIAG; // [R4]
                    nxt_r.cyc_cnt = fan_pwm_pkg::CYC_ZERO;
                end
            end
            fan_pwm_pkg::ST_DIAG: begin
                if (pulse_evt) begin
                    nxt_r.state = fan_pwm_pkg::ST_RUN; // [R6]
                    nxt_r.cyc_cnt = fan_pwm_pkg::CYC_ZERO;
                end else if (period_end && nxt_r.cyc_cnt == fan_pwm_pkg::DIAG_CYC) begin
                    nxt_r.state = fan_pwm_pkg::ST_STARTUP_RETRY; // [R10]
                    nxt_r.cyc_cnt = fan_pwm_pkg::CYC_ZERO;
                end
            end
            fan_pwm_pkg::ST_FAULT: begin
                nxt_r.cyc_cnt = fan_pwm_pkg::CYC_ZERO; // [R11]
            end
            default: begin
                nxt_r.state = fan_pwm_pkg::ST_FAULT;
            end
        endcase
        // Drive: full on in start-up and burst, proportional in run, off in fault
        unique case (nxt_r.state)
            fan_pwm_pkg::ST_RUN: begin
                nxt_r.fan_drive_output = (nxt_r.phase < nxt_r.duty); // [R1]
            end
            fan_pwm_pkg::ST_FAULT: begin
                nxt_r.fan_drive_output = 1'b0; // [R11]
            end
            default: begin
                nxt_r.fan_drive_output = 1'b1; // [R5] [R9]
            end
        endcase
        nxt_r.fault_n = (nxt_r.state != fan_pwm_pkg::ST_FAULT); // [R11]
    end

    // ******************************
    // State register
    // ******************************
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            r_ff <= '{state: fan_pwm_pkg::ST_STARTUP, div_cnt: '0, step_en: 1'b0,
                      phase: 8'h00, duty: fan_pwm_pkg::LEVEL_ZERO, cyc_cnt: 6'h00,
                      pulse_seen: 1'b0, pulse_sync: 3'h0, pulse_lvl: 1'b0,
                      fan_drive_output: 1'b0, fault_n: 1'b1};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign fan_drive_output_o = r_ff.fan_drive_output;
    assign fan_fault_n_o = r_ff.fault_n;

    // ******************************
    // Assertions
    // ******************************
    sequence s_fault_entry;
        r_ff.state == fan_pwm_pkg::ST_FAULT;
    endsequence

    // Start-up on two edges in a row, so the drive's reset value is not judged
    sequence s_startup_held;
        (r_ff.state == fan_pwm_pkg::ST_STARTUP) ##1 (r_ff.state == fan_pwm_pkg::ST_STARTUP);
    endsequence

    sequence s_first_start_end;
        (r_ff.state == fan_pwm_pkg::ST_STARTUP)
            ##1 (r_ff.state == fan_pwm_pkg::ST_STARTUP_RETRY);
    endsequence

    sequence s_burst_end;
        (r_ff.state == fan_pwm_pkg::ST_DIAG)
            ##1 (r_ff.state == fan_pwm_pkg::ST_STARTUP_RETRY);
    endsequence

    sequence s_retry_end;
        (r_ff.state == fan_pwm_pkg::ST_STARTUP_RETRY)
            ##1 (r_ff.state == fan_pwm_pkg::ST_FAULT);
    endsequence

    AST_FAULT_LATCH: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R11]
        s_fault_entry |=> (!fan_fault_n_o && !fan_drive_output_o) and s_fault_entry)
        else $error("Fault state not latched with drive off");
    AST_BURST_ON: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R5]
        (r_ff.state == fan_pwm_pkg::ST_DIAG) |-> fan_drive_output_o)
        else $error("Drive not on during diagnostic burst");
    AST_STARTUP_ON: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R9]
        s_startup_held |-> fan_drive_output_o)
        else $error("Drive not on during start-up");
    AST_DIAG_FROM_RUN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R4]
        (r_ff.state == fan_pwm_pkg::ST_RUN) ##1 (r_ff.state == fan_pwm_pkg::ST_DIAG)
        |-> $past(r_ff.cyc_cnt) == fan_pwm_pkg::MISS_WINDOW_CYC - 6'h01)
        else $error("Diagnostic started before window expired");
    AST_DIAG_EXIT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R6]
        (r_ff.state == fan_pwm_pkg::ST_DIAG && pulse_evt) |=> r_ff.state == fan_pwm_pkg::ST_RUN)
        else $error("Pulse in burst did not resume run");
    AST_RETRY_TO_FAULT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R10]
        (r_ff.state == fan_pwm_pkg::ST_DIAG) ##1 (r_ff.state == fan_pwm_pkg::ST_FAULT) |-> 1'b0)
        else $error("Burst skipped start-up retry");
    AST_DUTY_MAX: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R8]
        period_end |=> r_ff.duty >= $past(levels_i.min_speed_level))
        else $error("Duty below minimum-speed level");
    AST_DUTY_HOLD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R12]
        !period_end |=> $stable(r_ff.duty))
        else $error("Duty changed mid-period");
    AST_PWM_SHAPE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R1]
        (r_ff.state == fan_pwm_pkg::ST_RUN && $stable(r_ff.state))
        |-> fan_drive_output_o == (r_ff.phase < r_ff.duty))
        else $error("Run drive does not follow duty");
    AST_STARTUP_LEN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R9]
        s_first_start_end
            |-> $past(r_ff.cyc_cnt) == fan_pwm_pkg::STARTUP_CYC - fan_pwm_pkg::CYC_ONE)
        else $error("Start-up period length wrong");
    AST_BURST_LEN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R5]
        s_burst_end |-> $past(r_ff.cyc_cnt) == fan_pwm_pkg::DIAG_CYC - fan_pwm_pkg::CYC_ONE)
        else $error("Diagnostic burst length wrong");
    AST_RETRY_LEN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R10]
        s_retry_end |-> $past(r_ff.cyc_cnt) == fan_pwm_pkg::STARTUP_CYC - fan_pwm_pkg::CYC_ONE)
        else $error("Start-up retry length wrong");
    AST_RETRY_ON: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R10]
        (r_ff.state == fan_pwm_pkg::ST_STARTUP_RETRY) |-> fan_drive_output_o)
        else $error("Drive not on during start-up retry");
    AST_START_EXIT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R9]
        (r_ff.state == fan_pwm_pkg::ST_STARTUP && pulse_evt)
            |=> r_ff.state == fan_pwm_pkg::ST_RUN)
        else $error("Pulse in start-up did not enter run");
    AST_RETRY_EXIT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R10]
        (r_ff.state == fan_pwm_pkg::ST_STARTUP_RETRY && pulse_evt)
            |=> r_ff.state == fan_pwm_pkg::ST_RUN)
        else $error("Pulse in start-up retry did not enter run");
    AST_WINDOW_RESTART: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R4]
        (r_ff.state == fan_pwm_pkg::ST_RUN && pulse_evt)
            |=> r_ff.cyc_cnt == fan_pwm_pkg::CYC_ZERO)
        else $error("Pulse in run did not restart the window");
    AST_DIAG_WINDOW: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R6]
        (r_ff.state == fan_pwm_pkg::ST_DIAG && pulse_evt)
            |=> r_ff.cyc_cnt == fan_pwm_pkg::CYC_ZERO)
        else $error("Pulse in burst did not restart the window");
    AST_FAULT_N_HIGH: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R11]
        (r_ff.state != fan_pwm_pkg::ST_FAULT) |-> fan_fault_n_o)
        else $error("Fault output low outside fault state");
    AST_DUTY_TEMP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R8]
        period_end |=> r_ff.duty >= $past(levels_i.temp_control_level))
        else $error("Duty below temperature level");
    AST_DUTY_PICK: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R8]
        period_end |=> (r_ff.duty == $past(levels_i.temp_control_level)
            || r_ff.duty == $past(levels_i.min_speed_level)))
        else $error("Duty is neither of the two levels");

endmodule

// ### test/fan_model.sv
// Behavioural brushless fan that commutates only while energized
module fan_model (
    input wire logic clk_i, // Bench clock
    input wire logic drive_i, // Low-side switch on
    input wire logic spin_i, // Rotor free, low = stalled
    output logic pulse_o // Conditioned commutation pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int on_cnt = 0;
    initial pulse_o = 1'b0;
    // A pole needs 196 clocks of steady current before it commutates
    always @(posedge clk_i) begin
        on_cnt <= (drive_i && spin_i) ? on_cnt + 1 : 0;
        pulse_o <= drive_i && spin_i && (on_cnt % 200) > 195;
    end
endmodule

// ### test/fan_pwm_missing_pulse_ctrl_tb.sv
// Self-checking bench of the fan PWM controller
module fan_pwm_missing_pulse_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 2;
    localparam int PER = 255 * DIV;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic spin = 1'b1;
    fan_pwm_pkg::level_pair_t lv = '0;
    logic pulse;
    logic drv;
    logic flt_n;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    fan_pwm_missing_pulse_ctrl #(.STEP_DIV(DIV)) fan_pwm_missing_pulse_ctrl_i (
        .ref_clk_i(clk), .sys_rst_i(rst), .levels_i(lv), .commutation_pulse_i(pulse),
        .fan_drive_output_o(drv), .fan_fault_n_o(flt_n));
    fan_model fan_model_i (.clk_i(clk), .drive_i(drv), .spin_i(spin), .pulse_o(pulse));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wait_drv(input logic v, input int lim);
        for (int i = 0; i < lim && drv !== v; i++) @(negedge clk);
        chk("drive_level", 16'(v), 16'(drv));
    endtask
    task automatic count_high(input int n, output int hi);
        hi = 0;
        repeat (n) begin
            @(negedge clk);
            hi += int'(drv === 1'b1);
        end
    endtask
    task automatic do_reset;
        @(posedge clk) rst <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("rst_drive", 16'h0000, 16'(drv));
        chk("rst_fault_n", 16'h0001, 16'(flt_n));
        @(posedge clk) rst <= 1'b0;
    endtask
    task automatic t_startup;
        int hi;
        do_reset();
        repeat (3) @(negedge clk);
        count_high(150, hi);
        chk("startup_on", 16'd150, 16'(hi));
        $display("t_startup done");
    endtask
    task automatic t_duty;
        logic [15:0] tab [4] = '{16'hC010, 16'h4080, 16'hFF00, 16'h0000};
        int hi;
        int exp;
        foreach (tab[k]) begin
            @(posedge clk) lv <= tab[k];
            exp = (tab[k][15:8] > tab[k][7:0] ? tab[k][15:8] : tab[k][7:0]) * DIV;
            repeat (2 * PER) @(negedge clk);
            count_high(PER, hi);
            chk("on_clocks", 16'(exp), 16'(hi));
        end
        $display("t_duty done");
    endtask
    task automatic t_diag;
        int hi;
        wait_drv(1'b1, 34 * PER);
        count_high(150, hi);
        chk("burst_on", 16'd150, 16'(hi));
        wait_drv(1'b0, PER);
        count_high(PER, hi);
        chk("resume_off", 16'h0000, 16'(hi));
        chk("diag_fault_n", 16'h0001, 16'(flt_n));
        $display("t_diag done");
    endtask
    task automatic t_fault;
        int hi;
        @(posedge clk) spin <= 1'b0;
        wait_drv(1'b1, 34 * PER);
        hi = 0;
        while (drv === 1'b1 && hi < 40 * PER) begin
            @(negedge clk);
            hi++;
        end
        chk("retry_periods", 16'd35, 16'((hi + 8) / PER));
        @(negedge clk);
        chk("fault_n", 16'h0000, 16'(flt_n));
        @(posedge clk) spin <= 1'b1;
        count_high(PER, hi);
        chk("fault_drive", 16'h0000, 16'(hi));
        do_reset();
        repeat (3) @(negedge clk);
        chk("restart_drive", 16'h0001, 16'(drv));
        $display("t_fault done");
    endtask
    task automatic t_retry;
        int hi;
        @(posedge clk) spin <= 1'b0;
        do_reset();
        repeat (3) @(negedge clk);
        count_high(33 * PER, hi);
        chk("retry_on", 16'(33 * PER), 16'(hi));
        @(posedge clk) spin <= 1'b1;
        wait_drv(1'b0, PER);
        chk("retry_fault_n", 16'h0001, 16'(flt_n));
        $display("t_retry done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        t_startup();
        t_duty();
        t_diag();
        t_fault();
        t_retry();
        wrap_up();
    end
endmodule
